/* File: shared/ovfault_consts.vh */
`ifndef OVFAULT_CONSTS_VH
`define OVFAULT_CONSTS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CODE_HIGH_FAULT_LIMIT   8'h40
`define CODE_HIGH_FAULT_REACT   8'h41
`define CODE_HIGH_WARN_LIMIT    8'h42
`define CODE_LOW_WARN_LIMIT     8'h43
`define CODE_LOW_FAULT_LIMIT    8'h44
`define CODE_CLEAR_FAULTS       8'h03
`define CODE_FAULT_STATUS       8'he0

// ----------------------------------------
// Reaction register fields
// ----------------------------------------
`define REACT_MODE_HI           7
`define REACT_MODE_LO           6
`define REACT_RETRY_HI          5
`define REACT_RETRY_LO          3
`define REACT_DELAY_HI          2
`define REACT_DELAY_LO          0

// Response modes
`define MODE_IGNORE             2'h0
`define MODE_RIDE_THROUGH       2'h1
`define MODE_SHUT_RETRY         2'h2
`define MODE_OFF_WHILE_FAULT    2'h3

// Retry counts
`define RETRY_NONE              3'h0
`define RETRY_FOREVER           3'h7

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define STAT_HIGH_FAULT         0
`define STAT_LOW_FAULT          1
`define STAT_HIGH_WARN          2
`define STAT_LOW_WARN           3
`define STAT_WIDTH              4
`define STAT_ATTEMPT_LO         8
`define STAT_LOCK_BIT           11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_HIGH_FAULT_LIMIT    16'hffff
`define RST_HIGH_WARN_LIMIT     16'hffff
`define RST_LOW_WARN_LIMIT      16'h0000
`define RST_LOW_FAULT_LIMIT     16'h0000
`define RST_REACT               8'h80

`endif

/* File: src/delay_timer.v */
`timescale 1ns/1ps
module delay_timer (
  input  wire        clk,
  input  wire        reset,
  input  wire        start,
  input  wire [2:0]  delay_code,
  input  wire [15:0] unit_cycles,
  output reg         done
);

  // ----------------------------------------
  // Unit length and unit count
  // ----------------------------------------
  // A zero unit length would never expire, so it counts as one cycle
  wire [15:0] last_tick = (unit_cycles == 16'h0000) ? 16'h0000 : unit_cycles - 16'h0001;
  wire [7:0]  last_unit = (8'h01 << delay_code) - 8'h01;

  reg  [15:0] tick;
  reg  [7:0]  units;
  reg         running;

  // Done decoded from the counters so the owner acts on the edge that ends the interval
  always @* begin
    done = running && (tick == 16'h0000) && (units == 8'h00); // R6 R7
  end

  // Down counters; a new start restarts the whole interval
  always @(posedge clk) begin
    if (reset) begin
      tick    <= 16'h0000;
      units   <= 8'h00;
      running <= 1'b0;
    end else begin
      if (start) begin
        tick    <= last_tick;
        units   <= last_unit;
        running <= 1'b1;
      end else if (running) begin
        if (tick == 16'h0000) begin
          if (units == 8'h00) begin
            running <= 1'b0;
          end else begin
            units <= units - 8'h01;
            tick  <= last_tick;
          end
        end else begin
          tick <= tick - 16'h0001;
        end
      end
    end
  end

endmodule

/* File: src/output_voltage_fault_retry_supervisor.v */
// Behaviour
// R1 - Retry count zero: no restart after fault shutdown, output stays off.
// R2 - Retry code 001: exactly one restart; on failure output disabled.
// R3 - Codes 010 to 110: attempts equal the binary code value.
// R4 - Attempts used up: output off until the fault is cleared.
// R5 - Code 111: retry forever until commanded off, bias loss or other fault; only an off request or bias loss stops it, a low fault is retried.
// R6 - Start-to-start spacing of attempts is delay count times time unit.
// R7 - Delay code selects two to the code units, 1 to 128.
// R8 - Same delay count sets the ride-through time.
// R9 - Time unit length comes from a separate setting, not the reaction.
// R10 - Holds 16-bit high warning threshold at command 0x42.
// R11 - Holds 16-bit low warning threshold at command 0x43.
// R12 - Holds 16-bit low fault threshold at command 0x44.
// R13 - Response field: ignore, ride through, shut and retry, off while fault.
// R14 - Fault cleared by bit clear, clear command, off-on cycle or bias loss; an off request releases the lock but leaves the status bits set.
// R15 - Holds 16-bit high fault threshold at command 0x40.
// R16 - Warning flags on crossing warning thresholds, output unaffected.
// R17 - Attempt counter zeroed on fault clear or successful restart.
`timescale 1ns/1ps
`include "ovfault_consts.vh"
module output_voltage_fault_retry_supervisor (
  input  wire        clk,
  input  wire        reset,
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  input  wire [15:0] vout,
  input  wire [15:0] time_unit_cycles,
  input  wire        enable_request,
  input  wire        bias_ok,
  output reg  [15:0] rd_data,
  output reg         rd_valid,
  output reg         output_enable,
  output reg         high_warning,
  output reg         low_warning,
  output reg         fault_latched
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_RUN  = 3'd0;
  localparam S_RIDE = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_TRY  = 3'd3;
  localparam S_LOCK = 3'd4;
  localparam S_HOLD = 3'd5;

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  reg  [15:0]              high_fault_threshold;
  reg  [15:0]              output_high_warning_threshold;
  reg  [15:0]              output_low_warning_threshold;
  reg  [15:0]              output_low_fault_threshold;
  reg  [7:0]               output_high_fault_reaction;
  reg  [`STAT_WIDTH-1:0]   status;

  reg  [2:0]               state;
  reg  [2:0]               attempts;
  reg  [2:0]               next_state;
  reg  [2:0]               next_attempts;
  reg                      next_enable;
  reg                      timer_start;
  wire                     timer_done;

  // Reaction fields
  wire [1:0] mode       = output_high_fault_reaction[`REACT_MODE_HI:`REACT_MODE_LO];
  wire [2:0] retries    = output_high_fault_reaction[`REACT_RETRY_HI:`REACT_RETRY_LO];
  wire [2:0] delay_code = output_high_fault_reaction[`REACT_DELAY_HI:`REACT_DELAY_LO];

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire wr        = cmd_valid & cmd_write;
  wire clear_all = wr & (cmd_code == `CODE_CLEAR_FAULTS); // R14
  wire [`STAT_WIDTH-1:0] bit_clear = (wr && cmd_code == `CODE_FAULT_STATUS) ?
                                     cmd_wdata[`STAT_WIDTH-1:0] : {`STAT_WIDTH{1'b0}};
  // Off command or lost bias both count as the off half of an off-on cycle
  wire cycle_off = ~enable_request | ~bias_ok; // R14
  wire fault_clear = clear_all | bit_clear[`STAT_HIGH_FAULT] | bit_clear[`STAT_LOW_FAULT]; // R14

  // ----------------------------------------
  // Threshold comparisons
  // ----------------------------------------
  // Low checks only mean something while the output is driven
  wire over_fault  = vout > high_fault_threshold;
  wire under_fault = output_enable & (vout < output_low_fault_threshold);
  wire fault_now   = over_fault | under_fault;
  wire over_warn   = vout > output_high_warning_threshold; // R16
  wire under_warn  = output_enable & (vout < output_low_warning_threshold); // R16

  // Budget check; forever never runs out
  wire out_of_tries = (retries != `RETRY_FOREVER) && (attempts >= retries); // R3 R5

  // ----------------------------------------
  // Delay timer
  // ----------------------------------------
  // Unit length is an input so the reaction holds only the count
  delay_timer u_delay (
    .clk         (clk),
    .reset       (reset),
    .start       (timer_start),
    .delay_code  (delay_code),
    .unit_cycles (time_unit_cycles), // R9
    .done        (timer_done)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      high_fault_threshold          <= `RST_HIGH_FAULT_LIMIT;
      output_high_warning_threshold <= `RST_HIGH_WARN_LIMIT;
      output_low_warning_threshold  <= `RST_LOW_WARN_LIMIT;
      output_low_fault_threshold    <= `RST_LOW_FAULT_LIMIT;
      output_high_fault_reaction    <= `RST_REACT;
    end else if (wr) begin
      case (cmd_code)
        `CODE_HIGH_FAULT_LIMIT: high_fault_threshold          <= cmd_wdata; // R15
        `CODE_HIGH_FAULT_REACT: output_high_fault_reaction    <= cmd_wdata[7:0];
        `CODE_HIGH_WARN_LIMIT:  output_high_warning_threshold <= cmd_wdata; // R10
        `CODE_LOW_WARN_LIMIT:   output_low_warning_threshold  <= cmd_wdata; // R11
        `CODE_LOW_FAULT_LIMIT:  output_low_fault_threshold    <= cmd_wdata; // R12
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Unknown codes answer zero rather than stalling the host
  always @(posedge clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end else begin
      rd_valid <= cmd_valid & ~cmd_write;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `CODE_HIGH_FAULT_LIMIT: rd_data <= high_fault_threshold;
          `CODE_HIGH_FAULT_REACT: rd_data <= {8'h00, output_high_fault_reaction};
          `CODE_HIGH_WARN_LIMIT:  rd_data <= output_high_warning_threshold;
          `CODE_LOW_WARN_LIMIT:   rd_data <= output_low_warning_threshold;
          `CODE_LOW_FAULT_LIMIT:  rd_data <= output_low_fault_threshold;
          `CODE_FAULT_STATUS:     rd_data <= {4'h0, (state == S_LOCK), attempts, 4'h0, status};
          default:                rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Sticky status bits
  // ----------------------------------------
  // Set beats clear so an event during the clearing write is kept
  wire [`STAT_WIDTH-1:0] status_set = {under_warn, over_warn, under_fault, over_fault};
  wire                   clr_every  = clear_all | ~bias_ok;

  genvar i;
  generate
    for (i = 0; i < `STAT_WIDTH; i = i + 1) begin : g_status
      always @(posedge clk) begin
        if (reset) begin
          status[i] <= 1'b0;
        end else if (status_set[i]) begin
          status[i] <= 1'b1;
        end else if (clr_every || bit_clear[i]) begin
          status[i] <= 1'b0; // R14
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Restart policy, next state
  // ----------------------------------------
  always @* begin
    next_state    = state;
    next_attempts = attempts;
    next_enable   = output_enable;
    timer_start   = 1'b0;
    case (state)
      S_RUN: begin
        next_enable = 1'b1;
        if (fault_now) begin
          case (mode)
            `MODE_RIDE_THROUGH: begin
              next_state  = S_RIDE; // R13
              timer_start = 1'b1; // R8
            end
            `MODE_SHUT_RETRY: begin
              next_enable = 1'b0; // R13
              if (retries == `RETRY_NONE) begin
                next_state = S_LOCK; // R1
              end else begin
                next_state  = S_WAIT;
                timer_start = 1'b1; // R6
              end
            end
            `MODE_OFF_WHILE_FAULT: begin
              next_enable = 1'b0; // R13
              next_state  = S_HOLD;
            end
            default: ; // Ignore: keep running
          endcase
        end
      end
      S_RIDE: begin
        // Fault still present at the end of the ride-through
        if (timer_done) begin
          if (fault_now) begin
            next_enable = 1'b0; // R8
            if (retries == `RETRY_NONE) begin
              next_state = S_LOCK; // R1
            end else begin
              next_state  = S_WAIT;
              timer_start = 1'b1;
            end
          end else begin
            next_state = S_RUN;
          end
        end
      end
      S_WAIT: begin
        next_enable = 1'b0;
        if (timer_done) begin
          // Attempt starts here; the timer spans start to start
          next_enable = 1'b1;
          next_state  = S_TRY;
          timer_start = 1'b1; // R6 R7
          if (attempts != `RETRY_FOREVER) begin
            next_attempts = attempts + 3'd1; // R2 R3
          end
        end
      end
      S_TRY: begin
        if (fault_now) begin
          next_enable = 1'b0;
          if (out_of_tries) begin
            next_state = S_LOCK; // R2 R4
          end else begin
            next_state  = S_WAIT; // R5
            // Interval ending as the attempt fails would be lost; rearm so the wait cannot hang
            timer_start = timer_done;
          end
        end else if (timer_done) begin
          next_state    = S_RUN;
          next_attempts = 3'd0; // R17
        end
      end
      S_LOCK: begin
        next_enable = 1'b0; // R4
        if (fault_clear) begin
          next_state    = S_RUN; // R14
          next_attempts = 3'd0; // R17
          next_enable   = 1'b1;
        end
      end
      S_HOLD: begin
        // Output off, so only the high side can still be present
        next_enable = 1'b0;
        if (!over_fault) begin
          next_enable = 1'b1; // R13
          next_state  = S_RUN;
        end
      end
      default: begin
        next_state  = S_RUN;
        next_enable = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Restart policy, state registers
  // ----------------------------------------
  // An off request wins over everything but reset and clears the attempt count
  always @(posedge clk) begin
    if (reset) begin
      state         <= S_RUN;
      attempts      <= 3'd0;
      output_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else if (cycle_off) begin
      state         <= S_RUN; // R5 R14
      attempts      <= 3'd0; // R17
      output_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      state         <= next_state;
      attempts      <= next_attempts;
      output_enable <= next_enable;
      fault_latched <= (next_state == S_LOCK);
    end
  end

  // ----------------------------------------
  // Warning outputs
  // ----------------------------------------
  // Level flags only; they never touch the output enable
  always @(posedge clk) begin
    if (reset) begin
      high_warning <= 1'b0;
      low_warning  <= 1'b0;
    end else begin
      high_warning <= over_warn; // R16
      low_warning  <= under_warn; // R16
    end
  end

endmodule

/* File: verif/mgmt_host.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Management host: issues one command at a time
// ------------------------------------------------------------
module mgmt_host (
  input  wire        clk,
  output reg         cmd_valid,
  output reg         cmd_write,
  output reg  [7:0]  cmd_code,
  output reg  [15:0] cmd_wdata,
  input  wire [15:0] rd_data,
  input  wire        rd_valid
);
  // Idle lines start at zero, then show the inverse after each command so stale values never look valid
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Strobe for one edge, answer sampled one edge later
  task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic v);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_wdata = d;
    @(negedge clk);
    // Answer stands only until the next edge, so take it before releasing
    q = rd_data;
    v = rd_valid;
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_code  = ~c;
    cmd_wdata = ~d;
    @(negedge clk);
  endtask
endmodule

/* File: verif/ovfault_asserts.sv */
`timescale 1ns/1ps
`include "ovfault_consts.vh"
// ------------------------------------------------------------
// Port-level checker
// ------------------------------------------------------------
module ovfault_asserts (
  input wire        clk,
  input wire        reset,
  input wire        cmd_valid,
  input wire        cmd_write,
  input wire [7:0]  cmd_code,
  input wire [15:0] cmd_wdata,
  input wire [15:0] vout,
  input wire [15:0] time_unit_cycles,
  input wire        enable_request,
  input wire        bias_ok,
  input wire [15:0] rd_data,
  input wire        rd_valid,
  input wire        output_enable,
  input wire        high_warning,
  input wire        low_warning,
  input wire        fault_latched
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Any command that releases a lock
  wire rd_cmd = cmd_valid && !cmd_write;
  wire clr    = cmd_valid && cmd_write &&
                (cmd_code == `CODE_CLEAR_FAULTS || (cmd_code == `CODE_FAULT_STATUS && |cmd_wdata[1:0]));

  property p_rd_pulse; rd_cmd |=> rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
  property p_rd_only; rd_valid |-> $past(rd_cmd); endproperty
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  property p_rd_hold; !rd_cmd |=> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_lock_off; fault_latched |-> !output_enable; endproperty
  a_lock_off: assert property (p_lock_off) else $error("output on while locked");
  property p_lock_hold; fault_latched && enable_request && bias_ok && !clr |=> fault_latched; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped alone");
  property p_unlock; $fell(fault_latched) |-> $past(clr || !enable_request || !bias_ok); endproperty
  a_unlock: assert property (p_unlock) else $error("lock cleared without cause");
  property p_bias; !bias_ok |=> !output_enable && !fault_latched; endproperty
  a_bias: assert property (p_bias) else $error("bias loss ignored");
  property p_off_req; !enable_request |=> !output_enable; endproperty
  a_off_req: assert property (p_off_req) else $error("off request ignored");
  property p_on_cause; $rose(output_enable) |-> $past(enable_request && bias_ok && (!fault_latched || clr)); endproperty
  a_on_cause: assert property (p_on_cause) else $error("output on without cause");
endmodule

bind output_voltage_fault_retry_supervisor ovfault_asserts u_chk (
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .vout(vout), .time_unit_cycles(time_unit_cycles), .enable_request(enable_request),
  .bias_ok(bias_ok), .rd_data(rd_data), .rd_valid(rd_valid), .output_enable(output_enable),
  .high_warning(high_warning), .low_warning(low_warning), .fault_latched(fault_latched)
);

/* File: verif/test_output_voltage_fault_retry_supervisor.sv */
`timescale 1ns/1ps
`include "ovfault_consts.vh"
module test_output_voltage_fault_retry_supervisor;
  reg         clk, reset, enable_request, bias_ok;
  reg  [15:0] vout, time_unit_cycles;
  wire        cmd_valid, cmd_write, rd_valid, output_enable, high_warning, low_warning, fault_latched;
  wire [7:0]  cmd_code;
  wire [15:0] cmd_wdata, rd_data;
  int         miscompares, n_compared, i, n, g;
  logic [7:0]  codes [5] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
  logic [15:0] rstv [5]  = '{16'hffff, 16'h0080, 16'hffff, 16'h0000, 16'h0000};
  logic [15:0] pat [5]   = '{16'h1000, 16'hff90, 16'hfffe, 16'h0001, 16'h0000};
  logic [15:0] patr [5]  = '{16'h1000, 16'h0090, 16'hfffe, 16'h0001, 16'h0000};
  int          dcode [3] = '{0, 3, 7};
  int          unit [3]  = '{3, 2, 1};

  output_voltage_fault_retry_supervisor DUT (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .vout(vout), .time_unit_cycles(time_unit_cycles), .enable_request(enable_request),
    .bias_ok(bias_ok), .rd_data(rd_data), .rd_valid(rd_valid), .output_enable(output_enable),
    .high_warning(high_warning), .low_warning(low_warning), .fault_latched(fault_latched)
  );
  mgmt_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
                  .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  // ------------------------------------------------------------
  // Clock, watchdog, shared tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run is about 1500 cycles; 20000 means a hang
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        v;
    host.issue(1'b1, c, d, q, v);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] q;
    logic        v;
    host.issue(1'b0, c, 16'h0000, q, v);
    check({15'h0000, v}, 16'h0001);
    check(q, exp);
  endtask

  // Counts output turn-ons; gap is start-to-start of the first two
  task automatic watch(input int len, output int rises, output int gap);
    int   t, last;
    logic prev;
    rises = 0;
    gap   = 0;
    last  = 0;
    prev  = output_enable;
    for (t = 0; t < len; t++) begin
      @(negedge clk);
      if (output_enable === 1'b1 && prev !== 1'b1) begin
        rises++;
        if (rises == 2) gap = t - last;
        last = t;
      end
      prev = output_enable;
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares = 0; n_compared = 0;
    reset = 1'b1; vout = 16'h0800; time_unit_cycles = 16'h0002; enable_request = 1'b1; bias_ok = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    // Reset values, write and read back, reaction keeps low byte
    for (i = 0; i < 5; i++) begin
      rd(codes[i], rstv[i]);
      wr(codes[i], pat[i]);
      rd(codes[i], patr[i]);
    end
    rd(8'h55, 16'h0000);
    check({15'h0, output_enable}, 16'h0001);
    // Retry budget 0..6, alternating the two clear paths
    for (i = 0; i < 7; i++) begin
      wr(`CODE_HIGH_FAULT_REACT, 16'h0080 | (i << 3));
      vout = 16'h2000;
      watch(60, n, g);
      check(16'(n), 16'(i));
      check({15'h0, fault_latched}, 16'h0001);
      check({15'h0, output_enable}, 16'h0000);
      vout = 16'h0800;
      if (i % 2) wr(`CODE_FAULT_STATUS, 16'h0001);
      else wr(`CODE_CLEAR_FAULTS, 16'h0000);
      check({15'h0, output_enable}, 16'h0001);
    end
    // Endless retry, spacing is 2^code units; stop by off request
    for (i = 0; i < 3; i++) begin
      time_unit_cycles = 16'(unit[i]);
      wr(`CODE_HIGH_FAULT_REACT, 16'h00b8 | 16'(dcode[i]));
      vout = 16'h2000;
      watch(300, n, g);
      check(16'(g), 16'((1 << dcode[i]) * unit[i]));
      check({15'h0, fault_latched}, 16'h0000);
      enable_request = 1'b0;
      repeat (2) @(negedge clk);
      check({15'h0, output_enable}, 16'h0000);
      vout = 16'h0800;
      enable_request = 1'b1;
      repeat (3) @(negedge clk);
      check({15'h0, output_enable}, 16'h0001);
    end
    // Ride through 8 cycles, no retry, then bias loss clears all
    time_unit_cycles = 16'h0002;
    wr(`CODE_HIGH_FAULT_REACT, 16'h0042);
    vout = 16'h2000;
    n = 0;
    while (output_enable === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({15'h0, n >= 8 && n <= 10}, 16'h0001);
    check({15'h0, fault_latched}, 16'h0001);
    bias_ok = 1'b0;
    vout = 16'h0800;
    repeat (2) @(negedge clk);
    check({15'h0, fault_latched}, 16'h0000);
    bias_ok = 1'b1;
    repeat (3) @(negedge clk);
    rd(`CODE_FAULT_STATUS, 16'h0000);
    check({15'h0, output_enable}, 16'h0001);
    // Off only while the fault is present
    wr(`CODE_HIGH_FAULT_REACT, 16'h00c0);
    vout = 16'h2000;
    repeat (2) @(negedge clk);
    check({15'h0, output_enable, fault_latched}, 16'h0000);
    vout = 16'h0800;
    repeat (2) @(negedge clk);
    check({15'h0, output_enable}, 16'h0001);
    // Ignore mode plus warnings
    wr(`CODE_CLEAR_FAULTS, 16'h0000);
    wr(`CODE_HIGH_FAULT_REACT, 16'h0000);
    wr(`CODE_HIGH_WARN_LIMIT, 16'h1800);
    wr(`CODE_LOW_WARN_LIMIT, 16'h0400);
    vout = 16'h2000;
    repeat (3) @(negedge clk);
    check({14'h0, output_enable, high_warning}, 16'h0003);
    rd(`CODE_FAULT_STATUS, 16'h0005);
    vout = 16'h0200;
    repeat (3) @(negedge clk);
    check({13'h0, output_enable, high_warning, low_warning}, 16'h0005);
    // Under-voltage fault locks with no retry
    wr(`CODE_CLEAR_FAULTS, 16'h0000);
    wr(`CODE_LOW_FAULT_LIMIT, 16'h0300);
    rd(`CODE_LOW_FAULT_LIMIT, 16'h0300);
    wr(`CODE_HIGH_FAULT_REACT, 16'h0080);
    repeat (3) @(negedge clk);
    check({14'h0, output_enable, fault_latched}, 16'h0001);
    rd(`CODE_FAULT_STATUS, 16'h080a);
    report_and_stop();
  end
endmodule
